/* File: verilog/ocx_pkg.sv */
package ocx_pkg;

  // Target address upper bits
  localparam logic [2:0] ADDR_HI = 3'b110;

  // Register selectors
  localparam logic [7:0] REG_PART = 8'h50;
  localparam logic [7:0] REG_NOM = 8'h52;
  localparam logic [7:0] REG_LOT = 8'h56;
  localparam logic [7:0] REG_DATE = 8'h57;
  localparam logic [7:0] REG_PULL = 8'h61;
  localparam logic [7:0] REG_RANGE = 8'h62;
  localparam logic [7:0] REG_AGING = 8'h63;
  localparam logic [7:0] REG_RAMP = 8'h64;
  localparam logic [7:0] REG_UPTIME = 8'hA0;
  localparam logic [7:0] REG_TEMP = 8'hA1;
  localparam logic [7:0] REG_VSUP = 8'hA3;
  localparam logic [7:0] REG_HEAT = 8'hA7;
  localparam logic [7:0] REG_TOTAL = 8'hAB;
  localparam logic [7:0] REG_ERR = 8'hAE;
  localparam logic [7:0] REG_STAB = 8'hAF;
  localparam logic [7:0] REG_TERR = 8'hB0;
  localparam logic [7:0] REG_PTGT = 8'hB1;

  // Register group bounds
  localparam logic [7:0] DESC_LO = 8'h50;
  localparam logic [7:0] DESC_HI = 8'h57;
  localparam logic [7:0] CTL_LO = 8'h60;
  localparam logic [7:0] CTL_HI = 8'h6F;
  localparam logic [7:0] STAT_LO = 8'hA0;
  localparam logic [7:0] STAT_HI = 8'hB1;

  // Register sizes in bytes
  localparam logic [8:0] SZ_PART = 9'h100;
  localparam logic [8:0] SZ_TEXT = 9'h020;
  localparam logic [8:0] SZ_WORD = 9'h004;
  localparam int TXT_BYTES = 32;

  // Control values after reset
  localparam logic [31:0] RST_PULL = 32'h0000_0000;
  localparam logic [31:0] RST_RANGE = 32'h3727_C5AC;
  localparam logic [31:0] RST_AGING = 32'h0000_0000;
  localparam logic [31:0] RST_RAMP = 32'h3727_C5AC;

  // Float layout
  localparam int FLT_SIGN = 31;
  localparam int FLT_EXP_LSB = 23;
  localparam logic [8:0] FLT_BIAS = 9'h07F;

  // Clock stretch for the byte fetch
  localparam int CLK_NS = 5;
  localparam int STRETCH_NS = 40;
  localparam logic [3:0] STRETCH_CYC = 4'((STRETCH_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WRITE, ST_WRITE_ACK, ST_READ, ST_READ_ACK, ST_DONE
  } ocx_state_e;

  typedef struct packed {
    logic [31:0] pull;
    logic [31:0] range;
    logic [31:0] aging;
    logic [31:0] ramp;
  } ocx_ctl_s;

  typedef struct packed {
    logic [31:0] uptime;
    logic [31:0] temp;
    logic [31:0] vsup;
    logic [31:0] heater;
    logic [31:0] total;
    logic [31:0] err;
    logic [31:0] stable;
    logic [31:0] temp_err;
    logic [31:0] pwr_tgt;
  } ocx_stat_s;

  typedef struct packed {
    logic negative;
    logic is_zero;
    logic raise;
    logic lower;
    logic signed [8:0] exp_unb;
    logic [23:0] mant;
  } ocx_pull_s;

  // Group of a selector, 0 when outside every group
  function automatic logic [1:0] grp_of(input logic [7:0] s);
    if (s >= DESC_LO && s <= DESC_HI) grp_of = 2'h1;
    else if (s >= CTL_LO && s <= CTL_HI) grp_of = 2'h2;
    else if (s >= STAT_LO && s <= STAT_HI) grp_of = 2'h3;
    else grp_of = 2'h0;
  endfunction

  // Byte size of a selector; reserved ones read as one zero word
  function automatic logic [8:0] size_of(input logic [7:0] s);
    if (s == REG_PART) size_of = SZ_PART;
    else if (s == REG_NOM || s == REG_LOT || s == REG_DATE) size_of = SZ_TEXT;
    else size_of = SZ_WORD;
  endfunction

endpackage

/* File: verilog/ocx_i2c_port.sv */
`timescale 1ns/1ps
`default_nettype none
module ocx_i2c_port
  import ocx_pkg::*;
#(
  parameter logic [255:0] PART_TEXT = "OCXO-PART-0",
  parameter logic [255:0] NOM_TEXT = "10.000000MHz",
  parameter logic [255:0] LOT_TEXT = "LOT0-SN0",
  parameter logic [255:0] DATE_TEXT = "DATE0"
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus clock pin
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  // Bus data pin
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Address strap
  input wire logic [3:0] addr_opt,
  // Device side
  input wire ocx_stat_s stat,
  output ocx_ctl_s ctl,
  output ocx_pull_s pull_info,
  output logic ctl_upd
);

  ocx_state_e state_r;
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic scl_q_r;
  logic sda_q_r;
  logic [6:0] own_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic rw_r;
  logic ack_seen_r;
  logic first_r;
  logic wrote_r;
  logic exhaust_r;
  logic [7:0] sel_r;
  logic [8:0] idx_r;
  logic [3:0] stretch_r;
  logic sda_oe_r;
  logic ctl_upd_r;
  ocx_ctl_s ctl_r;
  ocx_pull_s pull_r;

  logic scl_rise;
  logic scl_fall;
  logic sda_rise;
  logic sda_fall;
  logic start_ev;
  logic stop_ev;
  logic byte_in;
  logic rd_adv;
  logic [7:0] nb;

  // Word byte, least significant first
  function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [8:0] i);
    if (i < SZ_WORD) word_byte = w[8*i[1:0] +: 8];
    else word_byte = 8'h00;
  endfunction

  // Text byte, leading pad skipped, zero past the end
  function automatic logic [7:0] text_byte(input logic [255:0] t, input logic [8:0] i);
    int lead;
    int pos;
    lead = 0;
    for (int k = 0; k < TXT_BYTES; k++) begin
      if (lead == k && t[8*(TXT_BYTES-1-k) +: 8] == 8'h00) lead = k + 1;
    end
    pos = lead + int'(i);
    text_byte = 8'h00;
    if (pos < TXT_BYTES) text_byte = t[8*(TXT_BYTES-1-pos) +: 8];
  endfunction

  // Byte returned for a selector and index
  function automatic logic [7:0] rd_byte(input logic [7:0] s, input logic [8:0] i,
                                         input ocx_ctl_s c, input ocx_stat_s st);
    if (s == REG_PART) rd_byte = text_byte(PART_TEXT, i);
    else if (s == REG_NOM) rd_byte = text_byte(NOM_TEXT, i);
    else if (s == REG_LOT) rd_byte = text_byte(LOT_TEXT, i);
    else if (s == REG_DATE) rd_byte = text_byte(DATE_TEXT, i);
    else if (s == REG_PULL) rd_byte = word_byte(c.pull, i);
    else if (s == REG_RANGE) rd_byte = word_byte(c.range, i);
    else if (s == REG_AGING) rd_byte = word_byte(c.aging, i);
    else if (s == REG_RAMP) rd_byte = word_byte(c.ramp, i);
    else if (s == REG_UPTIME) rd_byte = word_byte(st.uptime, i);
    else if (s == REG_TEMP) rd_byte = word_byte(st.temp, i);
    else if (s == REG_VSUP) rd_byte = word_byte(st.vsup, i);
    else if (s == REG_HEAT) rd_byte = word_byte(st.heater, i);
    else if (s == REG_TOTAL) rd_byte = word_byte(st.total, i);
    else if (s == REG_ERR) rd_byte = word_byte(st.err, i);
    else if (s == REG_STAB) rd_byte = word_byte(st.stable, i);
    else if (s == REG_TERR) rd_byte = word_byte(st.temp_err, i);
    else if (s == REG_PTGT) rd_byte = word_byte(st.pwr_tgt, i);
    else rd_byte = 8'h00;
  endfunction

  // Pin synchronisers, a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s_r <= 3'h7;
      sda_s_r <= 3'h7;
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_s_r <= {scl_s_r[1:0], scl_i};
      sda_s_r <= {sda_s_r[1:0], sda_i};
      if (scl_s_r[1] == scl_s_r[2]) scl_q_r <= scl_s_r[2];
      if (sda_s_r[1] == sda_s_r[2]) sda_q_r <= sda_s_r[2];
    end
  end

  // Bus events
  assign scl_rise = (scl_s_r[1] == scl_s_r[2]) && scl_s_r[2] && !scl_q_r;
  assign scl_fall = (scl_s_r[1] == scl_s_r[2]) && !scl_s_r[2] && scl_q_r;
  assign sda_rise = (sda_s_r[1] == sda_s_r[2]) && sda_s_r[2] && !sda_q_r;
  assign sda_fall = (sda_s_r[1] == sda_s_r[2]) && !sda_s_r[2] && sda_q_r;
  assign start_ev = sda_fall && scl_q_r && !scl_fall;
  assign stop_ev = sda_rise && scl_q_r && !scl_fall;
  assign byte_in = (state_r == ST_WRITE) && scl_fall && (bit_cnt_r == 4'h8);
  assign rd_adv = (state_r == ST_READ_ACK) && scl_rise && !sda_q_r;
  assign nb = rd_byte(sel_r, idx_r, ctl_r, stat);

  // Strap capture while reset is held
  always_ff @(posedge clk) begin
    if (!rst_n) own_r <= {ADDR_HI, addr_opt};
  end

  // Protocol state and data line drive
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      rw_r <= 1'b0;
      ack_seen_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (start_ev) begin
      state_r <= ST_ADDR;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (stop_ev) begin
      state_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR, ST_WRITE: begin
          if (scl_rise && bit_cnt_r != 4'h8) begin
            shift_r <= {shift_r[6:0], sda_q_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == 4'h8) begin
            bit_cnt_r <= 4'h0;
            if (state_r == ST_WRITE) begin
              state_r <= ST_WRITE_ACK;
              sda_oe_r <= 1'b1;
            end else if (shift_r[7:1] == own_r) begin
              state_r <= ST_ADDR_ACK;
              rw_r <= shift_r[0];
              sda_oe_r <= 1'b1;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              state_r <= ST_READ;
              tx_r <= nb;
              sda_oe_r <= !nb[7];
            end else begin
              state_r <= ST_WRITE;
              sda_oe_r <= 1'b0;
            end
          end
        end
        ST_WRITE_ACK: begin
          if (scl_fall) begin
            state_r <= ST_WRITE;
            sda_oe_r <= 1'b0;
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (bit_cnt_r == 4'h7) begin
              state_r <= ST_READ_ACK;
              sda_oe_r <= 1'b0;
            end else begin
              bit_cnt_r <= bit_cnt_r + 4'h1;
              sda_oe_r <= !tx_r[3'(4'h6 - bit_cnt_r)];
            end
          end
        end
        ST_READ_ACK: begin
          if (scl_rise) ack_seen_r <= !sda_q_r;
          if (scl_fall) begin
            bit_cnt_r <= 4'h0;
            if (ack_seen_r && !exhaust_r) begin
              state_r <= ST_READ;
              tx_r <= nb;
              sda_oe_r <= !nb[7];
            end else begin
              state_r <= ST_DONE;
            end
          end
        end
        default: begin
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  // Register pointer: selector, byte index, group end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_r <= 8'h00;
      idx_r <= 9'h000;
      first_r <= 1'b0;
      exhaust_r <= 1'b0;
    end else if (start_ev) begin
      first_r <= 1'b1;
      idx_r <= 9'h000;
      exhaust_r <= 1'b0;
    end else if (byte_in) begin
      if (first_r) begin
        sel_r <= shift_r;
        first_r <= 1'b0;
      end else if (idx_r != SZ_PART) begin
        idx_r <= idx_r + 9'h001;
      end
    end else if (rd_adv) begin
      if (idx_r + 9'h001 < size_of(sel_r)) begin
        idx_r <= idx_r + 9'h001;
      end else if (grp_of(sel_r) != 2'h0 && grp_of(sel_r + 8'h01) == grp_of(sel_r)) begin
        sel_r <= sel_r + 8'h01;
        idx_r <= 9'h000;
      end else begin
        exhaust_r <= 1'b1;
      end
    end
  end

  // Control register writes, byte lanes least significant first
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl_r <= '{pull: RST_PULL, range: RST_RANGE, aging: RST_AGING, ramp: RST_RAMP};
      wrote_r <= 1'b0;
      ctl_upd_r <= 1'b0;
    end else begin
      ctl_upd_r <= stop_ev && wrote_r;
      if (start_ev || stop_ev) wrote_r <= 1'b0;
      if (byte_in && !first_r && idx_r < SZ_WORD) begin
        if (sel_r == REG_PULL) ctl_r.pull[8*idx_r[1:0] +: 8] <= shift_r;
        else if (sel_r == REG_RANGE) ctl_r.range[8*idx_r[1:0] +: 8] <= shift_r;
        else if (sel_r == REG_AGING) ctl_r.aging[8*idx_r[1:0] +: 8] <= shift_r;
        else if (sel_r == REG_RAMP) ctl_r.ramp[8*idx_r[1:0] +: 8] <= shift_r;
        if (sel_r >= REG_PULL && sel_r <= REG_RAMP) wrote_r <= 1'b1;
      end
    end
  end

  // Pull offset decode: sign, unbiased exponent, mantissa, direction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pull_r <= '0;
      pull_r.is_zero <= 1'b1;
    end else begin
      pull_r.negative <= ctl_r.pull[FLT_SIGN];
      pull_r.is_zero <= (ctl_r.pull[30:0] == 31'h0000_0000);
      pull_r.exp_unb <= $signed({1'b0, ctl_r.pull[30:FLT_EXP_LSB]}) - $signed(FLT_BIAS);
      pull_r.mant <= {(ctl_r.pull[30:FLT_EXP_LSB] != 8'h00), ctl_r.pull[22:0]};
      pull_r.raise <= !ctl_r.pull[FLT_SIGN] && (ctl_r.pull[30:0] != 31'h0000_0000);
      pull_r.lower <= ctl_r.pull[FLT_SIGN] && (ctl_r.pull[30:0] != 31'h0000_0000);
    end
  end

  // Clock stretch while each read byte is fetched
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stretch_r <= 4'h0;
    end else if (scl_fall && ((state_r == ST_ADDR_ACK && rw_r)
                 || (state_r == ST_READ_ACK && ack_seen_r && !exhaust_r))) begin
      stretch_r <= STRETCH_CYC;
    end else if (stretch_r != 4'h0) begin
      stretch_r <= stretch_r - 4'h1;
    end
  end

  // Open-drain pins only ever pull low; target only, drives the clock only to stretch it
  assign scl_o = 1'b0;
  assign scl_oe = (stretch_r != 4'h0);
  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign ctl = ctl_r;
  assign pull_info = pull_r;
  assign ctl_upd = ctl_upd_r;

endmodule
`default_nettype wire

/* File: verification/ocx_i2c_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ocx_i2c_checker
  import ocx_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Bus pins
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_o,
  input wire logic sda_oe,
  // Device side
  input wire ocx_ctl_s ctl,
  input wire ocx_pull_s pull_info,
  input wire logic ctl_upd
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Stretch shape: eight cycles held, then let go
  sequence s_stretch;
    scl_oe [*8] ##1 !scl_oe;
  endsequence
  AST_STRETCH: assert property ($rose(scl_oe) |-> s_stretch)
    else $error("clock stretch length wrong");
  AST_OPEN_DRAIN: assert property (!scl_o && !sda_o)
    else $error("pin driven high");
  AST_SDA_IN_LOW: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data moved while clock high");
  AST_RST_VAL: assert property ($rose(rst_n) |-> ctl == {RST_PULL, RST_RANGE, RST_AGING, RST_RAMP} && !sda_oe)
    else $error("control words wrong after reset");
  AST_UPD_PULSE: assert property (ctl_upd |=> !ctl_upd)
    else $error("update strobe too long");
  AST_CTL_AFTER_ACK: assert property (!$stable(ctl) |-> $rose(sda_oe))
    else $error("control changed without an acknowledged byte");
  AST_SIGN: assert property (pull_info.negative == $past(ctl.pull[FLT_SIGN]))
    else $error("pull sign decode wrong");
  AST_EXP: assert property ($past(ctl.pull[30:23]) != 8'h00 |->
    pull_info.exp_unb == $signed({1'b0, $past(ctl.pull[30:23])}) - $signed(FLT_BIAS))
    else $error("pull exponent decode wrong");
  AST_MANT: assert property ($past(ctl.pull[30:23]) != 8'h00 |->
    pull_info.mant == {1'b1, $past(ctl.pull[22:0])})
    else $error("pull mantissa decode wrong");
  AST_DIR: assert property (!pull_info.is_zero |-> pull_info.lower == pull_info.negative
    && pull_info.raise == !pull_info.negative)
    else $error("pull direction wrong");
endmodule
bind ocx_i2c_port ocx_i2c_checker u_chk (.clk(clk), .rst_n(rst_n), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .ctl(ctl), .pull_info(pull_info), .ctl_upd(ctl_upd));
`default_nettype wire

/* File: verification/ocx_i2c_ctlr_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ocx_i2c_ctlr_model #(
  parameter int HALF = 16
)(
  // Clock
  input wire logic clk,
  // Resolved bus levels
  input wire logic scl,
  input wire logic sda,
  // Pull-downs, high while pulling low
  output logic scl_low,
  output logic sda_low
);
  int slow = 0;
  // Bus idles high on the pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: data set mid-low, clock let go, stretch waited out
  task automatic bit_io(input logic b, output logic seen);
    int n;
    n = 0;
    sda_low <= !b; // Released for ones
    tick(HALF / 2 + slow);
    scl_low <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (scl !== 1'b1 && n < 400); // Target may stall
    tick(HALF - 1);
    seen = sda;
    scl_low <= 1'b1;
    tick(HALF / 2);
  endtask
  // START from idle, or repeated START from a low phase
  task automatic start();
    sda_low <= 1'b0;
    tick(HALF / 2);
    scl_low <= 1'b0;
    tick(HALF);
    sda_low <= 1'b1;
    tick(HALF);
    scl_low <= 1'b1;
    tick(HALF / 2);
  endtask
  // STOP: data rises while clock high
  task automatic stop();
    sda_low <= 1'b1;
    tick(HALF / 2);
    scl_low <= 1'b0;
    tick(HALF);
    sda_low <= 1'b0;
    tick(HALF);
  endtask
  // Byte out MSB first, then the acknowledge clock
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s); // Eight bits
    bit_io(1'b1, s); // Released for the answer
    ack = !s;
  endtask
  // Byte in; acknowledge when more is wanted
  task automatic get(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!more, s); // Acknowledge unless last byte
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ocx_pkg::*;
  localparam logic [255:0] NOM = "10.000000MHz";
  logic clk, rst_n, scl_oe, sda_oe, ctl_upd, scl_low, sda_low, scl_w, sda_w, ack;
  logic [3:0] addr_opt;
  ocx_stat_s stat;
  ocx_ctl_s ctl, ctl_ref;
  ocx_pull_s pull_info;
  logic [255:0] got;
  logic [31:0] v;
  int num_errors = 0;
  int checks = 0;
  int upd_cnt = 0;
  int held_cnt = 0;
  int n, seed;
  // Open-drain wires resolved from both parties
  assign scl_w = !(scl_low || scl_oe);
  assign sda_w = !(sda_low || sda_oe);
  ocx_i2c_port #(.NOM_TEXT(NOM)) dut (.clk(clk), .rst_n(rst_n), .scl_i(scl_w), .scl_o(), .scl_oe(scl_oe),
    .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .addr_opt(addr_opt), .stat(stat), .ctl(ctl),
    .pull_info(pull_info), .ctl_upd(ctl_upd));
  ocx_i2c_ctlr_model u_host (.clk(clk), .scl(scl_w), .sda(sda_w), .scl_low(scl_low), .sda_low(sda_low));
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Update strobe counter
  always @(posedge clk) if (ctl_upd === 1'b1) upd_cnt++;
  // Cycles the target holds the clock after the host let go
  always @(posedge clk) if (scl_oe === 1'b1 && scl_low === 1'b0) held_cnt++;
  function automatic logic signed [8:0] exp_of(input logic [31:0] w);
    return $signed({1'b0, w[30:23]}) - $signed(9'h07F);
  endfunction
  // Text in bus order, first character lowest
  function automatic logic [95:0] text_le(input logic [95:0] s);
    for (int i = 0; i < 12; i++) text_le[8*i+:8] = s[8*(11-i)+:8];
  endfunction
  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s exp %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Address, selector, value bytes LSB first, STOP
  task automatic wr(input logic [7:0] sel, input int cnt, input logic [63:0] d);
    u_host.start();
    u_host.put({ADDR_HI, addr_opt, 1'b0}, ack);
    check("addr ack", ack, 1'b1);
    u_host.put(sel, ack);
    check("sel ack", ack, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      u_host.put(d[8*i+:8], ack);
      check("data ack", ack, 1'b1);
    end
    u_host.stop();
    repeat (6) @(posedge clk);
  endtask
  // Selector write, repeated START, read of cnt bytes
  task automatic rd(input logic [7:0] sel, input int cnt);
    logic [7:0] b;
    u_host.start();
    u_host.put({ADDR_HI, addr_opt, 1'b0}, ack);
    u_host.put(sel, ack);
    u_host.start();
    u_host.put({ADDR_HI, addr_opt, 1'b1}, ack);
    check("read addr ack", ack, 1'b1);
    got = '0;
    for (int i = 0; i < cnt; i++) begin
      u_host.get(i < cnt - 1, b);
      got[8*i+:8] = b;
    end
    u_host.stop();
  endtask
  // Watchdog
  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    seed = $urandom(32'h0DF2A488);
    rst_n = 1'b0;
    addr_opt = 4'h0;
    stat = '0;
    @(posedge clk);
    addr_opt <= 4'($urandom);
    for (int i = 0; i < 9; i++) stat[32*i+:32] <= $urandom;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("zero rst", pull_info.is_zero, 1'b1);
    // Foreign addresses are refused
    for (int i = 0; i < 4; i++) begin
      u_host.start();
      u_host.put({ADDR_HI ^ 3'(i == 0), addr_opt ^ 4'(i), 1'b0}, ack);
      check("foreign ack", ack, 1'b0);
      u_host.stop(); // Abandon
    end
    // Control writes, hand value first, then random, prompt and slow
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 32'h358637BD : {1'(i / 4), 8'($urandom_range(96, 144)), 23'($urandom)};
      ctl_ref = ctl;
      ctl_ref[32*(3-i%4)+:32] = v;
      n = upd_cnt;
      u_host.slow = 16 * (i % 2);
      wr(8'(REG_PULL + i % 4), 4, 64'(v));
      check("ctl", ctl, ctl_ref);
      check("upd", upd_cnt - n, 1);
      if (i % 4 == 0) begin
        check("raise", pull_info.raise, !v[31]);
        check("lower", pull_info.lower, v[31]);
        check("exp", pull_info.exp_unb, exp_of(v));
        check("zero", pull_info.is_zero, 1'b0);
        check("mant", pull_info.mant, {1'b1, v[22:0]});
      end
    end
    u_host.slow = 0;
    rd(REG_PULL, 16);
    check("ctl read", got[127:0], {ctl_ref.ramp, ctl_ref.aging, ctl_ref.range, ctl_ref.pull});
    // Read-only and reserved writes, and bytes past one word
    ctl_ref = ctl;
    n = upd_cnt;
    wr(REG_UPTIME, 4, 64'($urandom));
    wr(8'h60, 4, 64'($urandom));
    check("ro write", ctl, ctl_ref);
    check("ro upd", upd_cnt - n, 0);
    v = $urandom;
    wr(REG_RANGE, 6, {32'hFFFF_FFFF, v});
    ctl_ref.range = v;
    check("long write", ctl, ctl_ref);
    // Status reads, including past the group end
    // Short low phase, so the fetch stretch stalls the host
    u_host.slow = -6;
    rd(REG_UPTIME, 4);
    u_host.slow = 0;
    check("uptime", got[31:0], stat.uptime);
    check("stall", held_cnt != 0, 1'b1);
    rd(REG_TERR, 9);
    check("stat end", got[71:0], {8'hFF, stat.pwr_tgt, stat.temp_err});
    // Text register with its terminator
    rd(REG_NOM, 13);
    check("text", got[103:0], {8'h00, text_le(NOM[95:0])});
    wrap_up();
  end
endmodule
`default_nettype wire
